//--- design/adcxfr_channel.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module adcxfr_channel (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // converter core
  input wire logic conv_end,
  input wire logic conv_active,
  output logic conv_enable,
  // ram and result bus
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic mem_wide,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  // interrupt
  output logic irq
);

  adcxfr_pkg::adcxfr_state_t state_r;
  adcxfr_pkg::adcxfr_state_t state_nxt;

  logic [7:0] bls_r;
  logic [7:0] tc_r;
  logic [7:0] rld_r;
  logic [15:0] src_r;
  logic [15:0] dst_r;
  logic [15:0] src_init_r;
  logic [15:0] dst_init_r;
  logic [7:0] ctl_r;
  logic [7:0] den_r;
  logic [7:0] if_r;
  logic [7:0] mk_r;
  logic [7:0] adm_r;
  logic [15:0] reg_rdata_r;
  logic mem_rd_r;
  logic mem_wr_r;
  logic [15:0] mem_addr_r;
  logic mem_wide_r;
  logic [15:0] mem_wdata_r;
  logic irq_r;

  // address decode
  wire wr_bls = reg_wr & (reg_addr == adcxfr_pkg::OFF_BLOCK_SIZE);
  wire wr_tc = reg_wr & (reg_addr == adcxfr_pkg::OFF_XFER_COUNT);
  wire wr_rld = reg_wr & (reg_addr == adcxfr_pkg::OFF_XFER_RELOAD);
  wire wr_src = reg_wr & (reg_addr == adcxfr_pkg::OFF_SRC_ADDR);
  wire wr_dst = reg_wr & (reg_addr == adcxfr_pkg::OFF_DST_ADDR);
  wire wr_ctl = reg_wr & (reg_addr == adcxfr_pkg::OFF_XFER_CTRL);
  wire wr_den = reg_wr & (reg_addr == adcxfr_pkg::OFF_ACT_EN1);
  wire wr_if = reg_wr & (reg_addr == adcxfr_pkg::OFF_IRQ_FLAGS);
  wire wr_mk = reg_wr & (reg_addr == adcxfr_pkg::OFF_IRQ_MASK);
  wire wr_adm = reg_wr & (reg_addr == adcxfr_pkg::OFF_CONV_MODE0);

  // control fields
  wire rpt_mode = ctl_r[adcxfr_pkg::CTL_MODE];
  wire rpt_src = ctl_r[adcxfr_pkg::CTL_RPT_SEL];
  wire rpt_int = ctl_r[adcxfr_pkg::CTL_RPT_INT];
  wire size16 = ctl_r[adcxfr_pkg::CTL_SIZE];
  wire act_en = den_r[adcxfr_pkg::ACT_CONV_END];

  // the repeat area always steps; its own increment bit is then ignored
  wire src_adv = ctl_r[adcxfr_pkg::CTL_SRC_INC] | (rpt_mode & rpt_src);
  wire dst_adv = ctl_r[adcxfr_pkg::CTL_DST_INC] | (rpt_mode & ~rpt_src);

  // state decode
  wire st_idle = (state_r == adcxfr_pkg::ST_IDLE);
  wire st_cap = (state_r == adcxfr_pkg::ST_CAPTURE);
  wire st_wr = (state_r == adcxfr_pkg::ST_WRITE);
  wire st_fin = (state_r == adcxfr_pkg::ST_FINISH);

  // trigger and events
  wire trig = conv_end & act_en & st_idle;
  wire lost = conv_end & act_en & ~st_idle;
  wire direct_req = conv_end & ~act_en;
  wire unit_last;
  wire tc_last = (tc_r == 8'h01);
  wire fin_last = st_fin & tc_last;
  wire fin_end = fin_last & (~rpt_mode | rpt_int);
  wire fin_reload = fin_last & rpt_mode;
  wire [15:0] step = {14'h0000, mem_wide_r, ~mem_wide_r};

  // block unit counter, zero block size meaning 256 units
  adcxfr_units #(
    .W(8)
  ) u_units (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(trig),
    .load_val(bls_r),
    .dec(st_wr),
    .last(unit_last)
  );

  // sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      adcxfr_pkg::ST_IDLE: begin
        if (trig) begin
          state_nxt = adcxfr_pkg::ST_READ;
        end
      end
      adcxfr_pkg::ST_READ: begin
        state_nxt = adcxfr_pkg::ST_CAPTURE;
      end
      adcxfr_pkg::ST_CAPTURE: begin
        state_nxt = adcxfr_pkg::ST_WRITE;
      end
      adcxfr_pkg::ST_WRITE: begin
        state_nxt = unit_last ? adcxfr_pkg::ST_FINISH : adcxfr_pkg::ST_READ;
      end
      adcxfr_pkg::ST_FINISH: begin
        state_nxt = adcxfr_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = adcxfr_pkg::ST_IDLE;
      end
    endcase
  end

  // next values of software-visible registers
  wire [7:0] tc_nxt =
    wr_tc ? reg_wdata[7:0] :
    fin_reload ? rld_r :
    st_fin ? tc_r - 8'h01 : tc_r;

  wire [15:0] src_nxt =
    wr_src ? reg_wdata :
    (fin_reload & rpt_src) ? src_init_r :
    (st_cap & src_adv) ? src_r + step : src_r;

  wire [15:0] dst_nxt =
    wr_dst ? reg_wdata :
    (fin_reload & ~rpt_src) ? dst_init_r :
    (st_wr & dst_adv) ? dst_r + step : dst_r;

  // a hardware clear beats a software write landing in the same cycle
  wire [7:0] den_w = wr_den ? reg_wdata[7:0] : den_r;
  wire [7:0] den_clr = 8'h01 << adcxfr_pkg::ACT_CONV_END;
  wire [7:0] den_nxt = fin_end ? (den_w & ~den_clr) : den_w;

  // sticky flags: a set arriving with a clear wins
  wire [7:0] if_set =
    ({7'h00, direct_req | fin_end} << adcxfr_pkg::IRQ_CONV_END) |
    ({7'h00, lost} << adcxfr_pkg::IRQ_LOST);
  wire [7:0] if_clr = wr_if ? reg_wdata[7:0] : 8'h00;
  wire [7:0] if_nxt = (if_r & ~if_clr) | if_set;

  // read-back of conversion control follows the converter status
  wire conv_rb = adm_r[adcxfr_pkg::MODE0_CONV_CTL] & conv_active;
  wire [7:0] adm_rb = {conv_rb, adm_r[6:0]};

  // read mux; unmapped indices read zero
  wire [15:0] rd_mux =
    (reg_addr == adcxfr_pkg::OFF_BLOCK_SIZE) ? {8'h00, bls_r} :
    (reg_addr == adcxfr_pkg::OFF_XFER_COUNT) ? {8'h00, tc_r} :
    (reg_addr == adcxfr_pkg::OFF_XFER_RELOAD) ? {8'h00, rld_r} :
    (reg_addr == adcxfr_pkg::OFF_SRC_ADDR) ? src_r :
    (reg_addr == adcxfr_pkg::OFF_DST_ADDR) ? dst_r :
    (reg_addr == adcxfr_pkg::OFF_XFER_CTRL) ? {8'h00, ctl_r} :
    (reg_addr == adcxfr_pkg::OFF_ACT_EN1) ? {8'h00, den_r} :
    (reg_addr == adcxfr_pkg::OFF_IRQ_FLAGS) ? {8'h00, if_r} :
    (reg_addr == adcxfr_pkg::OFF_IRQ_MASK) ? {8'h00, mk_r} :
    (reg_addr == adcxfr_pkg::OFF_CONV_MODE0) ? {8'h00, adm_rb} :
    16'h0000;

  // transfer bus strobes and addresses
  wire go_read = (state_nxt == adcxfr_pkg::ST_READ);
  wire go_write = (state_nxt == adcxfr_pkg::ST_WRITE);
  wire [15:0] mem_addr_nxt = go_read ? src_r : go_write ? dst_r : mem_addr_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= adcxfr_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bls_r <= adcxfr_pkg::RST_BLOCK_SIZE;
      rld_r <= adcxfr_pkg::RST_XFER_RELOAD;
      ctl_r <= adcxfr_pkg::RST_XFER_CTRL;
      mk_r <= adcxfr_pkg::RST_IRQ_MASK;
      adm_r <= adcxfr_pkg::RST_CONV_MODE0;
    end else begin
      if (wr_bls) begin
        bls_r <= reg_wdata[7:0];
      end
      if (wr_rld) begin
        rld_r <= reg_wdata[7:0];
      end
      if (wr_ctl) begin
        ctl_r <= reg_wdata[7:0];
      end
      if (wr_mk) begin
        mk_r <= reg_wdata[7:0];
      end
      if (wr_adm) begin
        adm_r <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tc_r <= adcxfr_pkg::RST_XFER_COUNT;
      src_r <= adcxfr_pkg::RST_SRC_ADDR;
      dst_r <= adcxfr_pkg::RST_DST_ADDR;
      den_r <= adcxfr_pkg::RST_ACT_EN1;
      if_r <= adcxfr_pkg::RST_IRQ_FLAGS;
    end else begin
      tc_r <= tc_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      den_r <= den_nxt;
      if_r <= if_nxt;
    end
  end

  // start points of the repeat area, taken from software writes only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_init_r <= adcxfr_pkg::RST_SRC_ADDR;
      dst_init_r <= adcxfr_pkg::RST_DST_ADDR;
    end else begin
      if (wr_src) begin
        src_init_r <= reg_wdata;
      end
      if (wr_dst) begin
        dst_init_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wide_r <= 1'b0;
      mem_wdata_r <= 16'h0000;
    end else begin
      mem_rd_r <= go_read;
      mem_wr_r <= go_write;
      mem_addr_r <= mem_addr_nxt;
      if (trig) begin
        mem_wide_r <= size16;
      end
      if (st_cap) begin
        mem_wdata_r <= mem_rdata;
      end
    end
  end

  // irq lags the flags by one cycle so that it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
      irq_r <= |(if_r & ~mk_r);
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign conv_enable = adm_r[adcxfr_pkg::MODE0_CONV_CTL];
  assign mem_rd = mem_rd_r;
  assign mem_wr = mem_wr_r;
  assign mem_addr = mem_addr_r;
  assign mem_wide = mem_wide_r;
  assign mem_wdata = mem_wdata_r;
  assign irq = irq_r;

endmodule // adcxfr_channel

//--- design/adcxfr_pkg.sv
package adcxfr_pkg;

  // register indices on the plain register port
  localparam logic [3:0] OFF_BLOCK_SIZE = 4'h0;
  localparam logic [3:0] OFF_XFER_COUNT = 4'h1;
  localparam logic [3:0] OFF_XFER_RELOAD = 4'h2;
  localparam logic [3:0] OFF_SRC_ADDR = 4'h3;
  localparam logic [3:0] OFF_DST_ADDR = 4'h4;
  localparam logic [3:0] OFF_XFER_CTRL = 4'h5;
  localparam logic [3:0] OFF_ACT_EN1 = 4'h6;
  localparam logic [3:0] OFF_IRQ_FLAGS = 4'h7;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] OFF_CONV_MODE0 = 4'h9;

  // transfer control fields
  localparam int CTL_MODE = 0;
  localparam int CTL_RPT_SEL = 1;
  localparam int CTL_SRC_INC = 2;
  localparam int CTL_DST_INC = 3;
  localparam int CTL_RPT_INT = 5;
  localparam int CTL_SIZE = 6;

  // other field positions
  localparam int ACT_CONV_END = 6;
  localparam int IRQ_CONV_END = 0;
  localparam int IRQ_LOST = 1;
  localparam int MODE0_CONV_CTL = 7;

  // reset values
  localparam logic [7:0] RST_BLOCK_SIZE = 8'h00;
  localparam logic [7:0] RST_XFER_COUNT = 8'h00;
  localparam logic [7:0] RST_XFER_RELOAD = 8'h00;
  localparam logic [15:0] RST_SRC_ADDR = 16'h0000;
  localparam logic [15:0] RST_DST_ADDR = 16'h0000;
  localparam logic [7:0] RST_XFER_CTRL = 8'h00;
  localparam logic [7:0] RST_ACT_EN1 = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
  localparam logic [7:0] RST_CONV_MODE0 = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_WRITE = 3'b011,
    ST_FINISH = 3'b100
  } adcxfr_state_t;

endpackage

//--- design/adcxfr_units.sv
`timescale 1ns/1ps
// remaining units of one block; a load value of zero stands for 2**W
module adcxfr_units #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  // status
  output logic last
);

  logic [W:0] rem_r;
  logic [W:0] load_ext;

  assign load_ext = (load_val == '0) ? {1'b1, {W{1'b0}}} : {1'b0, load_val};
  assign last = (rem_r == {{W{1'b0}}, 1'b1});

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rem_r <= '0;
    end else if (load) begin
      rem_r <= load_ext;
    end else if (dec) begin
      rem_r <= rem_r - {{W{1'b0}}, 1'b1};
    end
  end

endmodule // adcxfr_units

//--- sim/adcxfr_properties.sv
`timescale 1ns/1ps
module adcxfr_checker (
  // clock and reset
  input logic clk_sys,
  input logic rst,
  // register port
  input logic [3:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata,
  // converter, memory and interrupt
  input logic conv_active,
  input logic conv_enable,
  input logic mem_rd,
  input logic mem_wr,
  input logic [15:0] mem_addr,
  input logic mem_wide,
  input logic [15:0] mem_wdata,
  input logic [15:0] mem_rdata,
  input logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic mask_full_r;
  wire mode_wr = reg_wr && reg_addr == adcxfr_pkg::OFF_CONV_MODE0;
  wire mode_rd = reg_rd && reg_addr == adcxfr_pkg::OFF_CONV_MODE0;
  // shadow of the mask, since the flags themselves are not visible here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_full_r <= 1'b1;
    end else if (reg_wr && reg_addr == adcxfr_pkg::OFF_IRQ_MASK) begin
      mask_full_r <= reg_wdata[7:0] == 8'hFF;
    end
  end
  a_unit_pair: assert property (mem_rd |-> ##2 mem_wr)
    else $error("unit read not followed by its write");
  a_no_overlap: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  a_addr_hold: assert property (mem_rd |=> $stable(mem_addr))
    else $error("address moved after read strobe");
  a_wide_held: assert property (mem_wr |-> mem_wide == $past(mem_wide, 2))
    else $error("unit width changed within a unit");
  a_wide_data: assert property (mem_wr && mem_wide |-> mem_wdata == $past(mem_rdata))
    else $error("wide unit data differs from read");
  a_byte_data: assert property (mem_wr |-> mem_wdata[7:0] == $past(mem_rdata[7:0]))
    else $error("written byte differs from read");
  a_mask_blocks: assert property (mask_full_r |=> !irq)
    else $error("interrupt while fully masked");
  a_conv_write: assert property (mode_wr |=> conv_enable == $past(reg_wdata[7]))
    else $error("conversion enable not as written");
  a_conv_idle: assert property (mode_rd && !conv_active |=> !reg_rdata[7])
    else $error("control reads 1 while converter idle");
  a_conv_busy: assert property (mode_rd && conv_active && conv_enable |=> reg_rdata[7])
    else $error("control reads 0 during conversion");
  c_wide: cover property (mem_wr && mem_wide);
  c_byte: cover property (mem_wr && !mem_wide);
  c_irq: cover property (irq);
endmodule // adcxfr_checker

bind adcxfr_channel adcxfr_checker u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .conv_active, .conv_enable, .mem_rd, .mem_wr, .mem_addr, .mem_wide, .mem_wdata,
  .mem_rdata, .irq);

//--- sim/adcxfr_mem_model.sv
`timescale 1ns/1ps
// result register and ram on the far side of the channel
module adcxfr_mem_model #(
  parameter logic [15:0] PAT = 16'h5A3C
) (
  // clock
  input logic clk_sys,
  // memory bus
  input logic mem_rd,
  input logic mem_wr,
  input logic [15:0] mem_addr,
  input logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] ram [0:255];
  initial mem_rdata = 16'h0000;
  // data is inverted outside the answer cycle so a capture one cycle late never matches
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      ram[mem_addr[7:0]] <= mem_wdata;
    end
    mem_rdata <= mem_rd ? mem_addr ^ PAT : ~mem_rdata;
  end
endmodule // adcxfr_mem_model

//--- sim/adcxfr_tb.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] SRC = 16'hFF1E;
  localparam logic [15:0] RES = SRC ^ 16'h5A3C;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic conv_end = 1'b0;
  logic conv_active = 1'b0;
  logic conv_enable, mem_rd, mem_wr, mem_wide, irq;
  logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  adcxfr_channel DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_end, .conv_active, .conv_enable, .mem_rd, .mem_wr, .mem_addr, .mem_wide,
    .mem_wdata, .mem_rdata, .irq);
  adcxfr_mem_model #(.PAT(16'h5A3C)) PM (.clk_sys, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata);
  always #2.5 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a full 256-byte block needs under 800 cycles; the rest is small
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_sim;
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // each access ends one edge after the strobe drops, so calls can follow
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
    @(posedge clk_sys);
  endtask
  task automatic trig(input int n);
    conv_end <= 1'b1;
    @(posedge clk_sys);
    conv_end <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic setup(input logic [7:0] blk, cnt, input logic [15:0] dst, input logic [7:0] ctl);
    wr(adcxfr_pkg::OFF_BLOCK_SIZE, {8'h00, blk});
    wr(adcxfr_pkg::OFF_XFER_COUNT, {8'h00, cnt});
    wr(adcxfr_pkg::OFF_XFER_RELOAD, {8'h00, cnt});
    wr(adcxfr_pkg::OFF_SRC_ADDR, SRC);
    wr(adcxfr_pkg::OFF_DST_ADDR, dst);
    wr(adcxfr_pkg::OFF_XFER_CTRL, {8'h00, ctl});
    wr(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0003);
    wr(adcxfr_pkg::OFF_ACT_EN1, 16'h0040);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      rc(4'(i), i == 8 ? 16'h00FF : 16'h0000);
    end
    wr(adcxfr_pkg::OFF_IRQ_MASK, 16'h0000);
    setup(8'h02, 8'h01, 16'h0010, 8'h48);
    trig(12);
    cmp(PM.ram[8'h12], RES);
    cmp(16'(irq), 16'h0001);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0014);
    rc(adcxfr_pkg::OFF_SRC_ADDR, SRC);
    rc(adcxfr_pkg::OFF_XFER_COUNT, 16'h0000);
    rc(adcxfr_pkg::OFF_ACT_EN1, 16'h0000);
    rc(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0001);
    wr(adcxfr_pkg::OFF_IRQ_MASK, 16'h00FF);
    #1 cmp(16'(irq), 16'h0000);
    wr(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0001);
    rc(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0000);
    trig(8);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0014);
    rc(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0001);
    setup(8'h00, 8'h01, 16'h0000, 8'h08);
    trig(800);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0100);
    cmp(PM.ram[8'hFF] & 16'h00FF, RES & 16'h00FF);
    setup(8'h01, 8'h02, 16'h0040, 8'h61);
    trig(8);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0042);
    rc(adcxfr_pkg::OFF_ACT_EN1, 16'h0040);
    rc(adcxfr_pkg::OFF_XFER_COUNT, 16'h0001);
    trig(8);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0040);
    rc(adcxfr_pkg::OFF_XFER_COUNT, 16'h0002);
    rc(adcxfr_pkg::OFF_SRC_ADDR, SRC);
    rc(adcxfr_pkg::OFF_ACT_EN1, 16'h0000);
    // source as repeat area; a second trigger lands while the first unit is still in flight
    setup(8'h01, 8'h02, 16'h0080, 8'h63);
    trig(1);
    trig(8);
    rc(adcxfr_pkg::OFF_SRC_ADDR, 16'hFF20);
    rc(adcxfr_pkg::OFF_DST_ADDR, 16'h0080);
    rc(adcxfr_pkg::OFF_XFER_COUNT, 16'h0001);
    rc(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0002);
    trig(8);
    cmp(PM.ram[8'h80], 16'hFF20 ^ 16'h5A3C);
    rc(adcxfr_pkg::OFF_SRC_ADDR, SRC);
    rc(adcxfr_pkg::OFF_XFER_COUNT, 16'h0002);
    rc(adcxfr_pkg::OFF_ACT_EN1, 16'h0000);
    rc(adcxfr_pkg::OFF_IRQ_FLAGS, 16'h0003);
    wr(adcxfr_pkg::OFF_CONV_MODE0, 16'h0080);
    rc(adcxfr_pkg::OFF_CONV_MODE0, 16'h0000);
    conv_active <= 1'b1;
    rc(adcxfr_pkg::OFF_CONV_MODE0, 16'h0080);
    cmp(16'(conv_enable), 16'h0001);
    wr(adcxfr_pkg::OFF_CONV_MODE0, 16'h0000);
    #1 cmp(16'(conv_enable), 16'h0000);
    end_sim;
  end
endmodule // testbench
